// >>> logic/eapc_pkg.sv
`default_nettype none
package eapc_pkg;
  // Register offsets on the control data port
  localparam logic [7:0] ADDR_ECS0 = 8'h01;
  localparam logic [7:0] ADDR_ECS1 = 8'h02;
  localparam logic [7:0] ADDR_ECS2 = 8'h03;
  localparam logic [7:0] ADDR_VCTL = 8'h04;
  localparam logic [7:0] ADDR_IDLO = 8'h05;
  localparam logic [7:0] ADDR_IDHI = 8'h06;
  localparam logic [7:0] ADDR_MKLO = 8'h07;
  localparam logic [7:0] ADDR_MKHI = 8'h08;
  localparam logic [7:0] ADDR_FCTL = 8'h17;
  localparam logic [7:0] ADDR_PCTL = 8'h18;
  // Field positions
  localparam int ECS0_FORCE = 7;
  localparam int ECS0_ENABLE = 6;
  localparam int ECS0_SDERR = 5;
  localparam int ECS1_FFERR = 7;
  localparam int ECS1_APERR = 6;
  localparam int ECS1_ANCERR = 5;
  localparam int VCTL_DEPTH_LSB = 5;
  localparam int VCTL_CSIN = 4;
  localparam int VCTL_CSFORCE = 3;
  localparam int VCTL_MISMATCH = 2;
  localparam int VCTL_FULL = 1;
  localparam int VCTL_EMPTY = 0;
  localparam int FCTL_INSERT = 7;
  localparam int FCTL_FLUSH = 6;
  localparam int FCTL_OVERRUN = 5;
  localparam int PCTL_PARDIS = 7;
  localparam int PCTL_VERTICAL_BLANK_ANC_ENABLE = 6;
  // Values after reset
  localparam logic [7:0] RST_ID = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [17:0] RST_CRC = 18'h00000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Video delay limits
  localparam logic [2:0] VDEPTH_MAX = 3'h4;
  // Tail writes after a packet, with or without an input checksum
  localparam logic [1:0] TAIL_WITH_CS = 2'h1;
  localparam logic [1:0] TAIL_APPEND_CS = 2'h2;

  typedef enum logic [2:0] {
    ANC_IDLE,
    ANC_SDID,
    ANC_DC,
    ANC_UDW,
    ANC_CS
  } eapc_anc_state_type;
endpackage
`default_nettype wire

// >>> logic/eapc_anc_mem.sv
`timescale 1ns/10ps
`default_nettype none
module eapc_anc_mem #(
  parameter int W = 10,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic mclk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [W-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [W-1:0] rd_data_o
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rd_data;
  } eapc_mem_state_type;

  eapc_mem_state_type s;
  eapc_mem_state_type next_s;

  // Read data registered so the output is a flop
  always_comb begin
    next_s = s;
    next_s.rd_data = s.mem[rd_addr_i];
    if (wr_en_i) begin
      next_s.mem[wr_addr_i] = wr_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    s <= next_s;
  end

  assign rd_data_o = s.rd_data;
endmodule
`default_nettype wire

// >>> logic/eapc_ctrl.sv
// Functional notes
// - Force bit inserts freshly computed checkwords
// - HD CRC always recomputed and inserted
// - CRC state starts at zero after reset
// - Checkword generator runs only when enabled
// - Flag SD input packets reporting errors
// - Store received flags while enabled
// - Flag error is OR of EDH, EDA
// - Video delay of zero to four stages
// - FIFO empty, full, overrun flags provided
// - Check received checksum when supplied
// - Mismatch with force replaces checksum
// - Mismatch without force sets mismatch flag
// - Append computed checksum when none supplied
// - Admit packet on masked identifier match
// - Masks reset to ones, identifiers zero
// - Insert from FIFO only when enabled
// - Flush empties FIFO then self-clears
// - Parity check on identifiers unless disabled
// - Vertical blanking insertion only when enabled
// - No HD insertion in protected lines
`timescale 1ns/10ps
`default_nettype none
module eapc_ctrl #(
  parameter int FIFO_DEPTH = 256,
  parameter int FIFO_AW = 8,
  parameter int VSTAGES = 4
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [19:0] vid_data_i,
  input wire logic vid_hd_i,
  input wire logic vid_crc_slot_i,
  input wire logic vid_crc_word_i,
  output logic [19:0] vid_data_o,
  input wire logic edh_pkt_valid_i,
  input wire logic [4:0] edh_ff_flags_i,
  input wire logic [4:0] edh_ap_flags_i,
  input wire logic [4:0] edh_anc_flags_i,
  input wire logic edh_slot_i,
  output logic edh_insert_o,
  output logic edh_regen_o,
  input wire logic [9:0] anc_data_i,
  input wire logic anc_valid_i,
  input wire logic anc_sop_i,
  input wire logic anc_space_i,
  input wire logic vblank_i,
  input wire logic hd_protect_i,
  output logic [9:0] anc_data_o,
  output logic anc_valid_o,
  output logic fifo_empty_o,
  output logic fifo_full_o,
  output logic fifo_overrun_o
);
  typedef struct packed {
    logic force_regen;
    logic gen_en;
    logic sd_err;
    logic [4:0] ff_flags;
    logic [4:0] ap_flags;
    logic [4:0] anc_flags;
    logic ff_err;
    logic ap_err;
    logic anc_err;
    logic [2:0] vdepth;
    logic cs_in;
    logic cs_force;
    logic cs_mism;
    logic ins_en;
    logic flush;
    logic overrun;
    logic par_dis;
    logic vertical_blank_anc_enable;
    logic [7:0] id_lo;
    logic [7:0] id_hi;
    logic [7:0] mk_lo;
    logic [7:0] mk_hi;
    logic [7:0] rdata;
    logic [VSTAGES-1:0][21:0] vdel;
    logic [19:0] vout;
    logic [17:0] crc_y;
    logic [17:0] crc_c;
    logic edh_ins;
    logic edh_regen;
    eapc_pkg::eapc_anc_state_type ast;
    logic [9:0] did;
    logic [9:0] pend;
    logic admit;
    logic [8:0] sum;
    logic [7:0] cnt;
    logic [1:0] tail;
    logic [FIFO_AW-1:0] wptr;
    logic [FIFO_AW-1:0] rptr;
    logic [FIFO_AW:0] count;
    logic aout_valid;
    logic fempty;
    logic ffull;
  } eapc_state_type;

  eapc_state_type s;
  eapc_state_type next_s;
  logic [9:0] mem_rdata;
  logic wr_req;
  logic [9:0] wr_word;
  logic mem_wr;
  logic rd_go;
  logic full;
  logic [21:0] vsel;
  logic [2:0] dsel;
  logic last_word;

  function automatic logic [17:0] eapc_crc18(input logic [17:0] c,
                                             input logic [9:0] d);
    logic [17:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 10; i++) begin
      fb = r[0] ^ d[i];
      r = {fb, r[17:1]};
      r[12] = r[12] ^ fb;
      r[13] = r[13] ^ fb;
    end
    return r;
  endfunction

  function automatic logic parity_ok(input logic [9:0] w);
    return (w[8] == ^w[7:0]) && (w[9] == ~w[8]);
  endfunction

  function automatic logic [9:0] cs_word(input logic [8:0] sm);
    return {~sm[8], sm};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    wr_req = 1'b0;
    wr_word = s.pend;
    mem_wr = 1'b0;
    rd_go = 1'b0;
    last_word = 1'b0;
    full = (s.count == FIFO_DEPTH[FIFO_AW:0]);
    next_s.flush = 1'b0;

    // Register writes; hardware set events below override clears
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        eapc_pkg::ADDR_ECS0: begin
          next_s.force_regen = reg_wdata_i[eapc_pkg::ECS0_FORCE];
          next_s.gen_en = reg_wdata_i[eapc_pkg::ECS0_ENABLE];
        end
        eapc_pkg::ADDR_VCTL: begin
          next_s.vdepth = reg_wdata_i[eapc_pkg::VCTL_DEPTH_LSB +: 3];
          next_s.cs_in = reg_wdata_i[eapc_pkg::VCTL_CSIN];
          next_s.cs_force = reg_wdata_i[eapc_pkg::VCTL_CSFORCE];
          if (reg_wdata_i[eapc_pkg::VCTL_MISMATCH]) begin
            next_s.cs_mism = 1'b0;
          end
        end
        eapc_pkg::ADDR_IDLO: next_s.id_lo = reg_wdata_i;
        eapc_pkg::ADDR_IDHI: next_s.id_hi = reg_wdata_i;
        eapc_pkg::ADDR_MKLO: next_s.mk_lo = reg_wdata_i;
        eapc_pkg::ADDR_MKHI: next_s.mk_hi = reg_wdata_i;
        eapc_pkg::ADDR_FCTL: begin
          next_s.ins_en = reg_wdata_i[eapc_pkg::FCTL_INSERT];
          next_s.flush = reg_wdata_i[eapc_pkg::FCTL_FLUSH];
          if (reg_wdata_i[eapc_pkg::FCTL_OVERRUN]) begin
            next_s.overrun = 1'b0;
          end
        end
        eapc_pkg::ADDR_PCTL: begin
          next_s.par_dis = reg_wdata_i[eapc_pkg::PCTL_PARDIS];
          next_s.vertical_blank_anc_enable = reg_wdata_i[eapc_pkg::PCTL_VERTICAL_BLANK_ANC_ENABLE];
        end
        default: begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // generator gated by enable
    next_s.edh_ins = edh_slot_i && s.gen_en;
    next_s.edh_regen = edh_slot_i && s.gen_en && s.force_regen;
    if (edh_pkt_valid_i && s.gen_en) begin
      next_s.ff_flags = edh_ff_flags_i;
      next_s.ap_flags = edh_ap_flags_i;
      next_s.anc_flags = edh_anc_flags_i;
      // OR of EDH and EDA bits
      next_s.ff_err = edh_ff_flags_i[0] | edh_ff_flags_i[1];
      next_s.ap_err = edh_ap_flags_i[0] | edh_ap_flags_i[1];
      next_s.anc_err = edh_anc_flags_i[0] | edh_anc_flags_i[1];
      next_s.sd_err = !vid_hd_i && (|{edh_ff_flags_i, edh_ap_flags_i,
                                      edh_anc_flags_i});
    end

    ////////////////////////////////////////////////////////////////////////
    // selectable delay, depth above max clamps
    next_s.vdel[0] = {vid_crc_slot_i, vid_crc_word_i, vid_data_i};
    for (int i = 1; i < VSTAGES; i++) begin
      next_s.vdel[i] = s.vdel[i-1];
    end
    dsel = (s.vdepth > eapc_pkg::VDEPTH_MAX) ? eapc_pkg::VDEPTH_MAX :
           s.vdepth;
    if (dsel == 3'h0) begin
      vsel = {vid_crc_slot_i, vid_crc_word_i, vid_data_i};
    end else begin
      vsel = s.vdel[dsel - 3'h1];
    end
    next_s.vout = vsel[19:0];
    // CRC words always replaced in HD
    if (vid_hd_i) begin
      if (vsel[21]) begin
        if (!vsel[20]) begin
          next_s.vout = {cs_word(s.crc_y[8:0]), cs_word(s.crc_c[8:0])};
        end else begin
          next_s.vout = {cs_word(s.crc_y[17:9]), cs_word(s.crc_c[17:9])};
          next_s.crc_y = eapc_pkg::RST_CRC;
          next_s.crc_c = eapc_pkg::RST_CRC;
        end
      end else begin
        next_s.crc_y = eapc_crc18(s.crc_y, vsel[19:10]);
        next_s.crc_c = eapc_crc18(s.crc_c, vsel[9:0]);
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tail writes drain the held word after a packet ends
    if (s.tail != 2'h0) begin
      wr_req = 1'b1;
      next_s.tail = s.tail - 2'h1;
      if (s.tail == eapc_pkg::TAIL_APPEND_CS) begin
        next_s.pend = cs_word(s.sum);
      end
    end
    if (anc_valid_i) begin
      next_s.sum = s.sum + anc_data_i[8:0];
      if (anc_sop_i) begin
        next_s.ast = eapc_pkg::ANC_SDID;
        next_s.did = anc_data_i;
        next_s.sum = anc_data_i[8:0];
        next_s.admit = 1'b0;
      end else begin
        unique case (s.ast)
          eapc_pkg::ANC_IDLE: next_s.sum = s.sum;
          eapc_pkg::ANC_SDID: begin
            next_s.admit =
              (((s.did[7:0] ^ s.id_lo) & ~s.mk_lo) == 8'h00) &&
              (((anc_data_i[7:0] ^ s.id_hi) & ~s.mk_hi) == 8'h00) &&
              (s.par_dis || (parity_ok(s.did) && parity_ok(anc_data_i)));
            wr_req = next_s.admit;
            wr_word = s.did;
            next_s.pend = anc_data_i;
            next_s.ast = eapc_pkg::ANC_DC;
          end
          eapc_pkg::ANC_DC: begin
            wr_req = s.admit;
            next_s.pend = anc_data_i;
            next_s.cnt = anc_data_i[7:0];
            last_word = (anc_data_i[7:0] == 8'h00);
            next_s.ast = eapc_pkg::ANC_UDW;
          end
          eapc_pkg::ANC_UDW: begin
            wr_req = s.admit;
            next_s.pend = anc_data_i;
            next_s.cnt = s.cnt - 8'h01;
            last_word = (s.cnt == 8'h01);
          end
          eapc_pkg::ANC_CS: begin
            wr_req = s.admit;
            next_s.ast = eapc_pkg::ANC_IDLE;
            next_s.pend = anc_data_i;
            if (anc_data_i[8:0] != s.sum) begin
              if (s.cs_force) begin
                next_s.pend = cs_word(s.sum);
              end else begin
                next_s.cs_mism = 1'b1;
              end
            end
            next_s.tail = s.admit ? eapc_pkg::TAIL_WITH_CS : 2'h0;
          end
          default: next_s.ast = eapc_pkg::ANC_IDLE;
        endcase
        if (last_word) begin
          if (s.cs_in) begin
            next_s.ast = eapc_pkg::ANC_CS;
          end else begin
            next_s.ast = eapc_pkg::ANC_IDLE;
            next_s.tail = s.admit ? eapc_pkg::TAIL_APPEND_CS : 2'h0;
          end
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // loads during a flush are dropped
    mem_wr = wr_req && !full && !s.flush;
    // write into a full FIFO is an overrun
    if (wr_req && full && !s.flush) begin
      next_s.overrun = 1'b1;
    end
    rd_go = s.ins_en && anc_space_i && (!vblank_i || s.vertical_blank_anc_enable) &&
            !(vid_hd_i && hd_protect_i) && (s.count != '0) && !s.flush;
    next_s.aout_valid = rd_go;
    if (mem_wr) begin
      next_s.wptr = s.wptr + 1'b1;
    end
    if (rd_go) begin
      next_s.rptr = s.rptr + 1'b1;
    end
    next_s.count = s.count + {{FIFO_AW{1'b0}}, mem_wr} -
                   {{FIFO_AW{1'b0}}, rd_go};
    if (s.flush) begin
      next_s.wptr = '0;
      next_s.rptr = '0;
      next_s.count = '0;
      next_s.aout_valid = 1'b0;
    end
    next_s.fempty = (next_s.count == '0);
    next_s.ffull = (next_s.count == FIFO_DEPTH[FIFO_AW:0]);

    ////////////////////////////////////////////////////////////////////////
    // Read data registered; status reflects current state
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        eapc_pkg::ADDR_ECS0:
          next_s.rdata = {s.force_regen, s.gen_en, s.sd_err, s.ff_flags};
        eapc_pkg::ADDR_ECS1:
          next_s.rdata = {s.ff_err, s.ap_err, s.anc_err, s.ap_flags};
        eapc_pkg::ADDR_ECS2: next_s.rdata = {3'h0, s.anc_flags};
        eapc_pkg::ADDR_VCTL:
          next_s.rdata = {s.vdepth, s.cs_in, s.cs_force, s.cs_mism, full,
                          (s.count == '0)};
        eapc_pkg::ADDR_IDLO: next_s.rdata = s.id_lo;
        eapc_pkg::ADDR_IDHI: next_s.rdata = s.id_hi;
        eapc_pkg::ADDR_MKLO: next_s.rdata = s.mk_lo;
        eapc_pkg::ADDR_MKHI: next_s.rdata = s.mk_hi;
        eapc_pkg::ADDR_FCTL:
          next_s.rdata = {s.ins_en, s.flush, s.overrun, 5'h00};
        eapc_pkg::ADDR_PCTL: next_s.rdata = {s.par_dis, s.vertical_blank_anc_enable, 6'h00};
        default: next_s.rdata = eapc_pkg::RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s <= '0;
      s.id_lo <= eapc_pkg::RST_ID;
      s.id_hi <= eapc_pkg::RST_ID;
      s.mk_lo <= eapc_pkg::RST_MASK;
      s.mk_hi <= eapc_pkg::RST_MASK;
      s.crc_y <= eapc_pkg::RST_CRC;
      s.crc_c <= eapc_pkg::RST_CRC;
      s.ast <= eapc_pkg::ANC_IDLE;
      s.fempty <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  eapc_anc_mem #(
    .W(10),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_mem (
    .mclk_i(mclk_i),
    .wr_en_i(mem_wr),
    .wr_addr_i(s.wptr),
    .wr_data_i(wr_word),
    .rd_addr_i(s.rptr),
    .rd_data_o(mem_rdata)
  );

  assign reg_rdata_o = s.rdata;
  assign vid_data_o = s.vout;
  assign edh_insert_o = s.edh_ins;
  assign edh_regen_o = s.edh_regen;
  assign anc_data_o = mem_rdata;
  assign anc_valid_o = s.aout_valid;
  assign fifo_empty_o = s.fempty;
  assign fifo_full_o = s.ffull;
  assign fifo_overrun_o = s.overrun;
endmodule
`default_nettype wire

// >>> bench/eapc_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module eapc_ctrl_checker (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic vid_hd_i,
  input wire logic edh_slot_i,
  input wire logic edh_insert_o,
  input wire logic edh_regen_o,
  input wire logic anc_space_i,
  input wire logic vblank_i,
  input wire logic hd_protect_i,
  input wire logic anc_valid_o,
  input wire logic fifo_empty_o,
  input wire logic fifo_full_o,
  input wire logic fifo_overrun_o
);
  logic gen_en;
  logic frc;
  logic ins_en;
  logic vertical_blank_anc_enable;
  logic wr_fctl;
  assign wr_fctl = reg_wr_i && reg_addr_i == eapc_pkg::ADDR_FCTL;
  // Shadow of control bits, updated on the same edge as the design
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      {gen_en, frc, ins_en, vertical_blank_anc_enable} <= 4'h0;
    end else if (reg_wr_i && reg_addr_i == eapc_pkg::ADDR_ECS0) begin
      gen_en <= reg_wdata_i[eapc_pkg::ECS0_ENABLE];
      frc <= reg_wdata_i[eapc_pkg::ECS0_FORCE];
    end else if (wr_fctl) begin
      ins_en <= reg_wdata_i[eapc_pkg::FCTL_INSERT];
    end else if (reg_wr_i && reg_addr_i == eapc_pkg::ADDR_PCTL) begin
      vertical_blank_anc_enable <= reg_wdata_i[eapc_pkg::PCTL_VERTICAL_BLANK_ANC_ENABLE];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  property p_flag_excl;
    !(fifo_empty_o && fifo_full_o);
  endproperty
  a_flag_excl: assert property (p_flag_excl)
    else $error("fifo empty and full together");
  property p_ovr_hold;
    fifo_overrun_o && !(wr_fctl && reg_wdata_i[5]) |=> fifo_overrun_o;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold)
    else $error("overrun dropped without a clear");
  property p_ins_gate;
    edh_slot_i |=> edh_insert_o == $past(gen_en);
  endproperty
  a_ins_gate: assert property (p_ins_gate)
    else $error("edh insert does not follow enable");
  property p_regen_gate;
    edh_slot_i && gen_en |=> edh_regen_o == $past(frc);
  endproperty
  a_regen_gate: assert property (p_regen_gate)
    else $error("edh regen does not follow force");
  property p_out_ins;
    anc_valid_o |-> $past(ins_en && anc_space_i && !fifo_empty_o);
  endproperty
  a_out_ins: assert property (p_out_ins)
    else $error("anc word sent while insertion off");
  property p_out_vbl;
    anc_valid_o |-> $past(!vblank_i || vertical_blank_anc_enable);
  endproperty
  a_out_vbl: assert property (p_out_vbl)
    else $error("anc word sent in blanking");
  property p_out_prot;
    anc_valid_o |-> !$past(vid_hd_i && hd_protect_i);
  endproperty
  a_out_prot: assert property (p_out_prot)
    else $error("anc word sent on protected line");
  property p_flush_empty;
    wr_fctl && reg_wdata_i[eapc_pkg::FCTL_FLUSH] |-> ##2 fifo_empty_o;
  endproperty
  a_flush_empty: assert property (p_flush_empty)
    else $error("fifo not empty after flush");
endmodule
bind eapc_ctrl eapc_ctrl_checker u_eapc_ctrl_checker (.*);
`default_nettype wire

// >>> bench/eapc_anc_src.sv
`timescale 1ns/10ps
`default_nettype none
module eapc_anc_src (
  input wire logic mclk_i,
  output logic [9:0] anc_data_o,
  output logic anc_valid_o,
  output logic anc_sop_o
);
  logic [9:0] sent [$];
  logic [9:0] good;
  initial begin
    anc_data_o = 10'h000;
    anc_valid_o = 1'h0;
    anc_sop_o = 1'h0;
  end
  // Parity in bit 8, its inverse in bit 9
  function automatic logic [9:0] pw(input logic [7:0] b);
    return {~(^b), ^b, b};
  endfunction
  // Mode bits: checksum sent, checksum corrupted, identifier parity bad
  task automatic send(input logic [7:0] did, input logic [7:0] sdid,
                      input logic [7:0] dc, input logic [2:0] mode);
    logic [8:0] s;
    s = 9'h000;
    sent.delete();
    sent.push_back(pw(did) ^ {{2{mode[2]}}, 8'h00});
    sent.push_back(pw(sdid));
    sent.push_back(pw(dc));
    for (int k = 0; k < dc; k++) begin
      sent.push_back(pw(8'h10 + 8'(k)));
    end
    foreach (sent[k]) begin
      s = s + sent[k][8:0];
    end
    good = {~s[8], s};
    if (mode[0]) begin
      sent.push_back(good ^ {9'h000, mode[1]});
    end
    foreach (sent[k]) begin
      @(posedge mclk_i);
      anc_data_o <= sent[k];
      anc_valid_o <= 1'h1;
      anc_sop_o <= (k == 0);
    end
    // Released bus shows the inverse, never a stale copy
    @(posedge mclk_i);
    anc_data_o <= ~anc_data_o;
    anc_valid_o <= 1'h0;
    anc_sop_o <= 1'h0;
    repeat (3) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [47:0] ids;
    logic [2:0] mode;
    logic frc;
    logic pdis;
    logic adm;
  } eapc_row_type;
  // did sdid id_lo id_hi mask_lo mask_hi, mode, force, pardis, admitted
  eapc_row_type rows [9] = '{
    '{48'h410500_00FFFF, 3'h0, 1'h0, 1'h0, 1'h1},
    '{48'h410541_050000, 3'h1, 1'h0, 1'h0, 1'h1},
    '{48'h420541_050000, 3'h1, 1'h0, 1'h0, 1'h0},
    '{48'h410641_050000, 3'h1, 1'h0, 1'h0, 1'h0},
    '{48'h4A0541_050F00, 3'h1, 1'h0, 1'h0, 1'h1},
    '{48'h410541_050000, 3'h3, 1'h1, 1'h0, 1'h1},
    '{48'h410541_050000, 3'h3, 1'h0, 1'h0, 1'h1},
    '{48'h410541_050000, 3'h5, 1'h0, 1'h0, 1'h0},
    '{48'h410541_050000, 3'h5, 1'h0, 1'h1, 1'h1}
  };
  logic [7:0] ra [6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h04};
  logic [7:0] re [6] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h01};
  logic mclk_i = 1'h0;
  logic srst_i = 1'h1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'h0;
  logic reg_rd_i = 1'h0;
  logic [7:0] reg_rdata_o;
  logic [19:0] vid_data_i = 20'h00000;
  logic [19:0] vid_data_o;
  logic vid_hd_i = 1'h0;
  logic vid_crc_slot_i = 1'h0;
  logic vid_crc_word_i = 1'h0;
  logic edh_pkt_valid_i = 1'h0;
  logic [4:0] edh_ff_flags_i = 5'h00;
  logic [4:0] edh_ap_flags_i = 5'h00;
  logic [4:0] edh_anc_flags_i = 5'h00;
  logic edh_slot_i = 1'h0;
  logic edh_insert_o;
  logic edh_regen_o;
  logic [9:0] anc_data_i;
  logic anc_valid_i;
  logic anc_sop_i;
  logic anc_space_i = 1'h1;
  logic vblank_i = 1'h0;
  logic hd_protect_i = 1'h0;
  logic [9:0] anc_data_o;
  logic anc_valid_o;
  logic fifo_empty_o;
  logic fifo_full_o;
  logic fifo_overrun_o;
  int mismatches = 0;
  int checks = 0;
  logic [7:0] rv;
  logic [1:0] ev;
  logic [9:0] got [$];
  logic [9:0] exp_q [$];
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    vid_data_i <= vid_data_i + 20'h00001;
  end
  // Small FIFO so an overflow is cheap to reach
  eapc_ctrl #(.FIFO_DEPTH(8), .FIFO_AW(3)) u_eapc_ctrl (.*);
  eapc_anc_src u_eapc_anc_src (.mclk_i(mclk_i), .anc_data_o(anc_data_i),
    .anc_valid_o(anc_valid_i), .anc_sop_o(anc_sop_i));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge mclk_i);
    reg_wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge mclk_i);
    reg_rd_i <= 1'h0;
    #1;
    rv = reg_rdata_o;
  endtask
  task automatic edh(input logic [4:0] f, input logic [4:0] a,
                     input logic [4:0] n);
    @(posedge mclk_i);
    edh_ff_flags_i <= f;
    edh_ap_flags_i <= a;
    edh_anc_flags_i <= n;
    edh_pkt_valid_i <= 1'h1;
    edh_slot_i <= 1'h1;
    @(posedge mclk_i);
    edh_pkt_valid_i <= 1'h0;
    edh_slot_i <= 1'h0;
    #1;
    ev = {edh_insert_o, edh_regen_o};
  endtask
  // Bounded collection of output words
  task automatic drain(input int n);
    got.delete();
    repeat (n) begin
      @(posedge mclk_i);
      #1;
      if (anc_valid_o === 1'h1) begin
        got.push_back(anc_data_o);
      end
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk_i);
    srst_i <= 1'h0;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(rv, re[i]);
    end
    wr(eapc_pkg::ADDR_ECS0, 8'h40);
    edh(5'h01, 5'h02, 5'h1C);
    chk(ev, 2'h2);
    rd(eapc_pkg::ADDR_ECS0);
    chk(rv, 8'h61);
    rd(eapc_pkg::ADDR_ECS1);
    chk(rv, 8'hC2);
    rd(eapc_pkg::ADDR_ECS2);
    chk(rv, 8'h1C);
    wr(eapc_pkg::ADDR_ECS0, 8'hC0);
    edh(5'h01, 5'h02, 5'h1C);
    chk(ev, 2'h3);
    wr(eapc_pkg::ADDR_ECS0, 8'h00);
    edh(5'h00, 5'h00, 5'h00);
    chk(ev, 2'h0);
    rd(eapc_pkg::ADDR_ECS0);
    chk(rv[4:0], 5'h01);
    for (int d = 0; d < 6; d++) begin
      rd(eapc_pkg::ADDR_VCTL);
      // merge new depth into old bits
      wr(eapc_pkg::ADDR_VCTL, (rv & 8'h1F) | 8'(d << 5));
      repeat (8) @(posedge mclk_i);
      #1;
      chk(vid_data_o, 20'(vid_data_i - 20'((d > 4 ? 4 : d) + 1)));
    end
    foreach (rows[r]) begin
      // flush only while the source is idle
      wr(eapc_pkg::ADDR_FCTL, 8'h40);
      wr(eapc_pkg::ADDR_VCTL, {3'h0, rows[r].mode[0], rows[r].frc, 3'h4});
      for (int k = 0; k < 4; k++) begin
        wr(eapc_pkg::ADDR_IDLO + 8'(k), rows[r].ids[8 * (3 - k) +: 8]);
      end
      wr(eapc_pkg::ADDR_PCTL, {rows[r].pdis, 7'h00});
      u_eapc_anc_src.send(rows[r].ids[47:40], rows[r].ids[39:32], 8'h03,
                          rows[r].mode);
      exp_q = u_eapc_anc_src.sent;
      if (!rows[r].mode[0]) begin
        exp_q.push_back(u_eapc_anc_src.good);
      end else if (rows[r].mode[1] && rows[r].frc) begin
        exp_q[exp_q.size() - 1] = u_eapc_anc_src.good;
      end
      if (!rows[r].adm) begin
        exp_q.delete();
      end
      rd(eapc_pkg::ADDR_VCTL);
      chk(rv[2], rows[r].mode == 3'h3 && !rows[r].frc);
      wr(eapc_pkg::ADDR_FCTL, 8'h80);
      drain(20);
      chk(got.size(), exp_q.size());
      foreach (exp_q[k]) begin
        chk(got[k], exp_q[k]);
      end
    end
    wr(eapc_pkg::ADDR_FCTL, 8'h40);
    u_eapc_anc_src.send(8'h41, 8'h05, 8'h08, 3'h1);
    rd(eapc_pkg::ADDR_VCTL);
    chk(rv[1:0], 2'h2);
    rd(eapc_pkg::ADDR_FCTL);
    chk({rv[5], fifo_overrun_o}, 2'h3);
    wr(eapc_pkg::ADDR_FCTL, 8'h20);
    rd(eapc_pkg::ADDR_FCTL);
    chk(rv[5], 1'h0);
    vblank_i <= 1'h1;
    wr(eapc_pkg::ADDR_FCTL, 8'h80);
    drain(10);
    chk(got.size(), 0);
    vblank_i <= 1'h0;
    vid_hd_i <= 1'h1;
    hd_protect_i <= 1'h1;
    drain(10);
    chk(got.size(), 0);
    hd_protect_i <= 1'h0;
    vblank_i <= 1'h1;
    wr(eapc_pkg::ADDR_PCTL, 8'hC0);
    drain(4);
    chk(got.size(), 4);
    chk(got[0], 10'h241);
    chk(fifo_empty_o, 1'h0);
    wr(eapc_pkg::ADDR_FCTL, 8'h40);
    rd(eapc_pkg::ADDR_FCTL);
    chk({rv[6], fifo_empty_o}, 2'h1);
    // Mid-run reset, HD CRC words restart from zero
    @(posedge mclk_i);
    srst_i <= 1'h1;
    vid_crc_slot_i <= 1'h1;
    vid_crc_word_i <= 1'h0;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'h0;
    @(posedge mclk_i);
    vid_crc_word_i <= 1'h1;
    #1;
    chk(vid_data_o, 20'h80200);
    chk({fifo_empty_o, fifo_overrun_o, anc_valid_o}, 3'h4);
    @(posedge mclk_i);
    vid_crc_slot_i <= 1'h0;
    #1;
    chk(vid_data_o, 20'h80200);
    rd(eapc_pkg::ADDR_MKHI);
    chk(rv, 8'hFF);
    tally_and_finish();
  end
endmodule
`default_nettype wire
